// File: include/scr_params.svh
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// ****************************************************************
// device register offsets (15-bit serial address)
// ****************************************************************
`define SCR_ADDR_CFG        15'h0000
`define SCR_ADDR_MODE       15'h0002
`define SCR_ADDR_ID_LO      15'h000c
`define SCR_ADDR_ID_HI      15'h000d
`define SCR_ADDR_USR        15'h0010
`define SCR_ADDR_CLK0       15'h0029
`define SCR_ADDR_POS0       15'h002c
`define SCR_ADDR_POS1       15'h002d
`define SCR_ADDR_POS2       15'h002e

// ****************************************************************
// field positions and codes
// ****************************************************************
`define SCR_CFG_RST_BIT     7
`define SCR_CFG_ASCEND_BIT  5
`define SCR_CFG_SDO_BIT     4
`define SCR_USR_HOLD_BIT    0
`define SCR_CLK0_RSV_BIT    7
`define SCR_CLK0_PROC_BIT   6
`define SCR_CLK0_RECV_BIT   5
`define SCR_CLK0_FINE_BIT   4
`define SCR_CLK0_SEL_MSB    3
`define SCR_MODE_PWR_DOWN   2'h3

// ****************************************************************
// reset values
// ****************************************************************
`define SCR_CFG_RST         8'h30
`define SCR_MODE_RST        8'h00
`define SCR_USR_RST         8'h00
`define SCR_CLK0_RST        8'h80

// ****************************************************************
// timing
// ****************************************************************
`define SCR_CLK_PERIOD_NS   100
`define SCR_RST_TIME_NS     750
`define SCR_RST_CYCLES      ((`SCR_RST_TIME_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)
`define SCR_SCLK_HALF       4

// ****************************************************************
// host command port offsets
// ****************************************************************
`define SCR_H_TADDR_LO      4'h0
`define SCR_H_TADDR_HI      4'h1
`define SCR_H_WDATA         4'h2
`define SCR_H_CTRL          4'h3
`define SCR_H_STATUS        4'h4
`define SCR_H_RDATA         4'h5

`endif

// File: include/scr_pkg.sv
package scr_pkg;

  // device frame states
  typedef enum logic [1:0] {
    SCR_D_IDLE  = 2'b00,
    SCR_D_INSTR = 2'b01,
    SCR_D_DATA  = 2'b10
  } scr_dev_st_t;

  // host frame states
  typedef enum logic [2:0] {
    SCR_H_IDLE  = 3'b000,
    SCR_H_LOW   = 3'b001,
    SCR_H_HIGH  = 3'b010,
    SCR_H_TAIL  = 3'b011,
    SCR_H_GUARD = 3'b100
  } scr_host_st_t;

endpackage

// File: include/scr_spi_if.sv
`timescale 1ns/1ps
`default_nettype none

// four-wire serial port; read data only ever returns on sdo
interface scr_spi_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;

  modport dev  (input sclk, input cs_n, input sdi, output sdo);
  modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface

`default_nettype wire

// File: verilog/scr_spi_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "scr_params.svh"


module scr_spi_dev #(
  parameter int          RST_CYCLES = `SCR_RST_CYCLES,
  parameter logic [15:0] MAKER_CODE = 16'h5a3c  // arbitrary value
) (
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // serial port
  scr_spi_if.dev           spi,
  // device controls
  output logic             device_power_down,
  output logic             chip_reset_active,
  // sysref controls and status
  output logic             sysref_receiver_enable,
  output logic             sysref_processor_enable,
  output logic             sysref_fine_window_scale,
  output logic [3:0]       sysref_delay_select,
  input  wire logic [23:0] sysref_edge_position_status,
  input  wire logic        sysref_event,
  output logic             sysref_event_taken
);

  if (RST_CYCLES < 1 || RST_CYCLES > 65535) begin : g_chk
    $error("RST_CYCLES out of range");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0]  pin_raw;
  logic [2:0]  s1_reg;
  logic [2:0]  s2_reg;
  logic        sclk_prev_reg;
  wire         sclk_s = s2_reg[2];
  wire         cs_n_s = s2_reg[1];
  wire         sdi_s  = s2_reg[0];
  wire         rise   = sclk_s & ~sclk_prev_reg;

  assign pin_raw = {spi.sclk, spi.cs_n, spi.sdi};

  // two flops per pin; only the second stage feeds logic
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        s1_reg[i] <= (i == 1) ? 1'b1 : 1'b0;
        s2_reg[i] <= (i == 1) ? 1'b1 : 1'b0;
      end else begin
        s1_reg[i] <= pin_raw[i];
        s2_reg[i] <= s1_reg[i];
      end
    end
  end

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0]  cfg_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  usr_reg;
  logic [7:0]  clk0_reg;
  logic [15:0] srst_cnt_reg;
  logic        taken_reg;

  // frame state
  scr_pkg::scr_dev_st_t st_reg;
  logic [3:0]  bit_cnt_reg;
  logic [15:0] instr_reg;
  logic        rd_reg;
  logic [14:0] addr_reg;
  logic [7:0]  din_reg;
  logic [7:0]  dout_reg;
  logic        load_pend_reg;

  wire         soft_busy = (srst_cnt_reg != 16'h0000);
  wire         in_data   = (st_reg == scr_pkg::SCR_D_DATA);
  wire         byte_end  = rise & in_data & (bit_cnt_reg == 4'h7);
  wire         instr_end = rise & (st_reg == scr_pkg::SCR_D_INSTR) & (bit_cnt_reg == 4'hf);
  wire [7:0]   wr_byte   = {din_reg[6:0], sdi_s};
  wire         wr_en     = byte_end & ~rd_reg & ~cs_n_s;
  wire         wr_cfg    = wr_en & (addr_reg == `SCR_ADDR_CFG);
  wire         wr_mode   = wr_en & (addr_reg == `SCR_ADDR_MODE);
  wire         wr_usr    = wr_en & (addr_reg == `SCR_ADDR_USR);
  wire         wr_clk0   = wr_en & (addr_reg == `SCR_ADDR_CLK0);
  wire         chip_rst  = wr_cfg & wr_byte[`SCR_CFG_RST_BIT];

  // ****************************************************************
  // streaming address step
  // ****************************************************************
  wire         hold      = usr_reg[`SCR_USR_HOLD_BIT];
  wire         ascend    = cfg_reg[`SCR_CFG_ASCEND_BIT];
  wire [14:0]  addr_up   = 15'(addr_reg + 15'h0001);
  wire [14:0]  addr_dn   = 15'(addr_reg - 15'h0001);
  wire [14:0]  addr_step = hold ? addr_reg :
                           ascend ? addr_up : addr_dn;

  // read decode; unmapped addresses read zero
  function automatic logic [7:0] rd_mux(input logic [14:0] a);
    case (a)
      `SCR_ADDR_CFG:   rd_mux = cfg_reg;
      `SCR_ADDR_MODE:  rd_mux = mode_reg;
      `SCR_ADDR_ID_LO: rd_mux = MAKER_CODE[7:0];
      `SCR_ADDR_ID_HI: rd_mux = MAKER_CODE[15:8];
      `SCR_ADDR_USR:   rd_mux = usr_reg;
      `SCR_ADDR_CLK0:  rd_mux = clk0_reg;
      `SCR_ADDR_POS0:  rd_mux = sysref_edge_position_status[7:0];
      `SCR_ADDR_POS1:  rd_mux = sysref_edge_position_status[15:8];
      `SCR_ADDR_POS2:  rd_mux = sysref_edge_position_status[23:16];
      default:         rd_mux = 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // chip reset timer
  // ****************************************************************
  // the timer outlasts the write frame so any frame inside it is dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      srst_cnt_reg <= 16'h0000;
    end else if (chip_rst) begin
      srst_cnt_reg <= 16'(RST_CYCLES);
    end else if (soft_busy) begin
      srst_cnt_reg <= 16'(srst_cnt_reg - 16'h0001);
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // chip reset forces every register back; cfg bit 7 is never stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg  <= `SCR_CFG_RST;
      mode_reg <= `SCR_MODE_RST;
      usr_reg  <= `SCR_USR_RST;
      clk0_reg <= `SCR_CLK0_RST;
    end else if (soft_busy || chip_rst) begin
      cfg_reg  <= `SCR_CFG_RST;
      mode_reg <= `SCR_MODE_RST;
      usr_reg  <= `SCR_USR_RST;
      clk0_reg <= `SCR_CLK0_RST;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= {1'b0, wr_byte[6:5], 1'b1, wr_byte[3:0]};
      end
      if (wr_mode) begin
        mode_reg <= wr_byte;
      end
      if (wr_usr) begin
        usr_reg <= wr_byte;
      end
      if (wr_clk0) begin
        clk0_reg <= wr_byte;
      end
    end
  end

  // ****************************************************************
  // serial frame engine
  // ****************************************************************
  // 16-bit instruction (read flag, 15-bit address) then data bytes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg        <= scr_pkg::SCR_D_IDLE;
      bit_cnt_reg   <= 4'h0;
      instr_reg     <= 16'h0000;
      rd_reg        <= 1'b0;
      addr_reg      <= 15'h0000;
      din_reg       <= 8'h00;
      dout_reg      <= 8'h00;
      load_pend_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
      load_pend_reg <= 1'b0;
      if (load_pend_reg) begin
        dout_reg <= rd_mux(addr_reg);
      end
      if (cs_n_s || soft_busy || chip_rst) begin
        st_reg      <= scr_pkg::SCR_D_IDLE;
        bit_cnt_reg <= 4'h0;
      end else begin
        case (st_reg)
          scr_pkg::SCR_D_IDLE: begin
            st_reg      <= scr_pkg::SCR_D_INSTR;
            bit_cnt_reg <= 4'h0;
          end
          scr_pkg::SCR_D_INSTR: begin
            if (rise) begin
              instr_reg   <= {instr_reg[14:0], sdi_s};
              bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            end
            if (instr_end) begin
              st_reg        <= scr_pkg::SCR_D_DATA;
              rd_reg        <= instr_reg[14];
              addr_reg      <= {instr_reg[13:0], sdi_s};
              load_pend_reg <= 1'b1;
            end
          end
          scr_pkg::SCR_D_DATA: begin
            if (rise) begin
              din_reg     <= wr_byte;
              dout_reg    <= {dout_reg[6:0], 1'b0};
              bit_cnt_reg <= (bit_cnt_reg == 4'h7) ? 4'h0 : 4'(bit_cnt_reg + 4'h1);
            end
            if (byte_end) begin
              addr_reg      <= addr_step;
              load_pend_reg <= 1'b1;
            end
          end
          default: begin
            st_reg <= scr_pkg::SCR_D_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // sysref event gate
  // ****************************************************************
  // an event counts only with receiver and processor both on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      taken_reg <= 1'b0;
    end else begin
      taken_reg <= sysref_event & clk0_reg[`SCR_CLK0_PROC_BIT]
                   & clk0_reg[`SCR_CLK0_RECV_BIT];
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // read data leaves only on sdo; there is no shared data pin
  assign spi.sdo                  = dout_reg[7];
  assign device_power_down        = (mode_reg[1:0] == `SCR_MODE_PWR_DOWN);
  assign chip_reset_active        = soft_busy;
  assign sysref_receiver_enable   = clk0_reg[`SCR_CLK0_RECV_BIT];
  assign sysref_processor_enable  = clk0_reg[`SCR_CLK0_PROC_BIT];
  assign sysref_fine_window_scale = clk0_reg[`SCR_CLK0_FINE_BIT];
  assign sysref_delay_select      = clk0_reg[`SCR_CLK0_SEL_MSB:0];
  assign sysref_event_taken       = taken_reg;

endmodule

`default_nettype wire

// File: verilog/scr_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "scr_params.svh"

module scr_spi_host #(
  parameter int SCLK_HALF   = `SCR_SCLK_HALF,
  parameter int GUARD_CYCLES = `SCR_RST_CYCLES
) (
  // system
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // command port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  // serial port
  scr_spi_if.host         spi
);

  // sdo round trip needs about three cycles of each half period
  if (SCLK_HALF < 4 || SCLK_HALF > 65535 ||
      GUARD_CYCLES < 1 || GUARD_CYCLES > 65535) begin : g_chk
    $error("host timing parameters out of range");
  end

  // ****************************************************************
  // command registers
  // ****************************************************************
  logic [14:0] taddr_reg;
  logic [7:0]  wdat_reg;
  logic [7:0]  rdat_reg;
  logic        done_reg;
  logic        soft_reg;
  logic [7:0]  rdata_reg;
  logic        sdo_s1_reg;
  logic        sdo_s2_reg;

  // frame registers
  scr_pkg::scr_host_st_t st_reg;
  logic [15:0] cnt_reg;
  logic [4:0]  bits_reg;
  logic [23:0] tx_reg;
  logic [7:0]  rx_reg;
  logic        sclk_reg;
  logic        cs_n_reg;
  logic        sdi_reg;

  // keeps reserved bits at default and receiver on with processor
  function automatic logic [7:0] fix_byte(input logic [14:0] a, input logic [7:0] d);
    case (a)
      `SCR_ADDR_CFG:  fix_byte = {d[7], 1'b0, d[5], 1'b1, 4'h0};
      `SCR_ADDR_MODE: fix_byte = {6'h00, d[1:0]};
      `SCR_ADDR_USR:  fix_byte = {7'h00, d[0]};
      `SCR_ADDR_CLK0: fix_byte = {1'b1, d[6], d[5] | d[6], d[4:0]};
      default:        fix_byte = d;
    endcase
  endfunction

  wire       busy     = (st_reg != scr_pkg::SCR_H_IDLE);
  wire       cmd_wr   = wr & (addr == `SCR_H_CTRL);
  wire       go_wr    = cmd_wr & wdata[0] & ~wdata[1] & ~busy;
  wire       go_rd    = cmd_wr & wdata[1] & ~busy;
  wire [7:0] tx_byte  = fix_byte(taddr_reg, wdat_reg);
  wire       end_done = (st_reg == scr_pkg::SCR_H_GUARD) & (cnt_reg == 16'h0000);
  wire       clr_done = wr & (addr == `SCR_H_STATUS) & wdata[1];
  wire       cnt_zero = (cnt_reg == 16'h0000);

  // ****************************************************************
  // command port
  // ****************************************************************
  // done is sticky; completion in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      taddr_reg <= 15'h0000;
      wdat_reg  <= 8'h00;
      done_reg  <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      if (wr && addr == `SCR_H_TADDR_LO && !busy) begin
        taddr_reg[7:0] <= wdata;
      end
      if (wr && addr == `SCR_H_TADDR_HI && !busy) begin
        taddr_reg[14:8] <= wdata[6:0];
      end
      if (wr && addr == `SCR_H_WDATA && !busy) begin
        wdat_reg <= wdata;
      end
      done_reg <= end_done | (done_reg & ~clr_done);
      case (addr)
        `SCR_H_TADDR_LO: rdata_reg <= rd ? taddr_reg[7:0] : 8'h00;
        `SCR_H_TADDR_HI: rdata_reg <= rd ? {1'b0, taddr_reg[14:8]} : 8'h00;
        `SCR_H_WDATA:    rdata_reg <= rd ? wdat_reg : 8'h00;
        `SCR_H_STATUS:   rdata_reg <= rd ? {5'h00, soft_reg & busy, done_reg, busy} : 8'h00;
        `SCR_H_RDATA:    rdata_reg <= rd ? rdat_reg : 8'h00;
        default:         rdata_reg <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // serial engine
  // ****************************************************************
  // sdo is sampled through two flops just as sclk rises
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sdo_s1_reg <= 1'b0;
      sdo_s2_reg <= 1'b0;
      st_reg     <= scr_pkg::SCR_H_IDLE;
      cnt_reg    <= 16'h0000;
      bits_reg   <= 5'h00;
      tx_reg     <= 24'h000000;
      rx_reg     <= 8'h00;
      rdat_reg   <= 8'h00;
      soft_reg   <= 1'b0;
      sclk_reg   <= 1'b0;
      cs_n_reg   <= 1'b1;
      sdi_reg    <= 1'b0;
    end else begin
      sdo_s1_reg <= spi.sdo;
      sdo_s2_reg <= sdo_s1_reg;
      case (st_reg)
        scr_pkg::SCR_H_IDLE: begin
          if (go_wr || go_rd) begin
            tx_reg   <= {go_rd, taddr_reg, go_rd ? 8'h00 : tx_byte};
            sdi_reg  <= go_rd;
            soft_reg <= ~go_rd & (taddr_reg == `SCR_ADDR_CFG) & tx_byte[`SCR_CFG_RST_BIT];
            cs_n_reg <= 1'b0;
            bits_reg <= 5'h00;
            cnt_reg  <= 16'(SCLK_HALF - 1);
            st_reg   <= scr_pkg::SCR_H_LOW;
          end
        end
        scr_pkg::SCR_H_LOW: begin
          cnt_reg <= 16'(cnt_reg - 16'h0001);
          if (cnt_zero) begin
            sclk_reg <= 1'b1;
            rx_reg   <= {rx_reg[6:0], sdo_s2_reg};
            cnt_reg  <= 16'(SCLK_HALF - 1);
            st_reg   <= scr_pkg::SCR_H_HIGH;
          end
        end
        scr_pkg::SCR_H_HIGH: begin
          cnt_reg <= 16'(cnt_reg - 16'h0001);
          if (cnt_zero) begin
            sclk_reg <= 1'b0;
            tx_reg   <= {tx_reg[22:0], 1'b0};
            sdi_reg  <= tx_reg[22];
            bits_reg <= 5'(bits_reg + 5'h01);
            cnt_reg  <= 16'(SCLK_HALF - 1);
            st_reg   <= (bits_reg == 5'd23) ? scr_pkg::SCR_H_TAIL : scr_pkg::SCR_H_LOW;
          end
        end
        scr_pkg::SCR_H_TAIL: begin
          cnt_reg <= 16'(cnt_reg - 16'h0001);
          if (cnt_zero) begin
            cs_n_reg <= 1'b1;
            rdat_reg <= rx_reg;
            sdi_reg  <= 1'b0;
            cnt_reg  <= soft_reg ? 16'(GUARD_CYCLES - 1) : 16'(SCLK_HALF - 1);
            st_reg   <= scr_pkg::SCR_H_GUARD;
          end
        end
        scr_pkg::SCR_H_GUARD: begin
          cnt_reg <= 16'(cnt_reg - 16'h0001);
          if (cnt_zero) begin
            st_reg <= scr_pkg::SCR_H_IDLE;
          end
        end
        default: begin
          st_reg <= scr_pkg::SCR_H_IDLE;
        end
      endcase
    end
  end

  assign spi.sclk = sclk_reg;
  assign spi.cs_n = cs_n_reg;
  assign spi.sdi  = sdi_reg;
  assign rdata    = rdata_reg;

endmodule

`default_nettype wire

// File: bench/scr_spi_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// wire checks on the serial port between host and device
// ****************************************************************
module scr_spi_monitor #(
  parameter logic [15:0] MAKER_CODE = 16'h5a3c  // arbitrary value
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo
);
  logic        sclk_reg;
  logic [23:0] frame_reg;
  logic [7:0]  reply_reg;
  logic [5:0]  bits_reg;
  wire         rise   = sclk & ~sclk_reg;
  wire  [14:0] faddr  = frame_reg[22:8];
  wire         rd_end = frame_reg[23];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // shift both lines at each serial rise; frames stay readable at cs_n rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg  <= 1'b0;
      frame_reg <= 24'h000000;
      reply_reg <= 8'h00;
      bits_reg  <= 6'h00;
    end else begin
      sclk_reg  <= sclk;
      frame_reg <= rise ? {frame_reg[22:0], sdi} : frame_reg;
      reply_reg <= rise ? {reply_reg[6:0], sdo} : reply_reg;
      bits_reg  <= cs_n ? 6'h00 : bits_reg + {5'h00, rise};
    end
  end

  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_sclk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  a_sclk_low: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  a_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("data in changed while serial clock high");
  a_frame_len: assert property ($rose(cs_n) |-> bits_reg == 6'd24)
    else $error("frame not twenty-four bits");
  a_reset_wait: assert property (
    $rose(cs_n) && !rd_end && faddr == 15'h0 && frame_reg[7] |-> cs_n [*8])
    else $error("frame started too soon after chip reset");
  a_sdo_flag: assert property (
    $rose(cs_n) && rd_end && faddr == 15'h0 |-> reply_reg[4])
    else $error("serial output flag read as zero");
  a_reset_clear: assert property (
    $rose(cs_n) && rd_end && faddr == 15'h0 |-> !reply_reg[7])
    else $error("chip reset bit read as one");
  a_maker_code: assert property ($rose(cs_n) && rd_end && faddr[14:1] == 14'h6 |->
    reply_reg == (faddr[0] ? MAKER_CODE[15:8] : MAKER_CODE[7:0]))
    else $error("maker code byte wrong");
  a_mode_rsv: assert property (
    $rose(cs_n) && rd_end && faddr == 15'h2 |-> reply_reg[7:2] == 6'h00)
    else $error("mode reserved bits not zero");
  a_clk0_write: assert property (
    $rose(cs_n) && !rd_end && faddr == 15'h29 |-> frame_reg[7] && (!frame_reg[6] || frame_reg[5]))
    else $error("clock control written with bad reserved or enable order");
endmodule

`default_nettype wire

// File: bench/spi_config_and_sysref_ctrl_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "scr_params.svh"

// ****************************************************************
// host and device joined, register model compared at every read
// ****************************************************************
module spi_config_and_sysref_ctrl_regs_test;
  localparam logic [15:0] MAKER = 16'h3c96;  // arbitrary value
  logic       clk_sys = 0, rst_n = 0, wr = 0, rd = 0, ev = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, q;
  logic [23:0] pos = 0;
  wire logic [7:0] rdata;
  wire logic pd, recv, proc, fine, taken, crst;
  wire logic [3:0] sel;
  integer     num_errors = 0, num_checks = 0, seed = 32'h4173, cyc = 0, i, rst_cyc = 0;
  logic [7:0] mdl [0:63];
  int         regs [9] = '{0, 2, 12, 13, 16, 41, 44, 45, 46};

  scr_spi_if spi_bus ();
  scr_spi_host #(.SCLK_HALF(4), .GUARD_CYCLES(8)) scr_spi_host_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .spi(spi_bus.host));
  scr_spi_dev #(.RST_CYCLES(8), .MAKER_CODE(MAKER)) scr_spi_dev_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .spi(spi_bus.dev), .device_power_down(pd), .chip_reset_active(crst),
    .sysref_receiver_enable(recv), .sysref_processor_enable(proc), .sysref_fine_window_scale(fine),
    .sysref_delay_select(sel), .sysref_edge_position_status(pos), .sysref_event(ev),
    .sysref_event_taken(taken));
  scr_spi_monitor #(.MAKER_CODE(MAKER)) scr_spi_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .sclk(spi_bus.sclk), .cs_n(spi_bus.cs_n), .sdi(spi_bus.sdi), .sdo(spi_bus.sdo));

  always #50 clk_sys = ~clk_sys;

  // a hung frame shows up as a run past the cycle ceiling; chip reset cycles are counted too
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rst_cyc <= rst_cyc + crst;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_outs(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // register model; the host forces reserved fields to their defaults
  function automatic void mreset();
    mdl = '{default: 8'h00};
    mdl[0] = 8'h30;
    mdl[41] = 8'h80;
  endfunction

  function automatic void mwrite(input logic [14:0] a, input logic [7:0] d);
    case (a)
      15'h0: if (d[7]) mreset(); else mdl[0] = {2'b00, d[5], 5'h10};
      15'h2: mdl[2] = {6'h00, d[1:0]};
      15'h10: mdl[16] = {7'h00, d[0]};
      15'h29: mdl[41] = {1'b1, d[6], d[5] | d[6], d[4:0]};
      default: ;
    endcase
  endfunction

  function automatic logic [7:0] mread(input logic [14:0] a);
    case (a)
      15'hc: return MAKER[7:0];
      15'hd: return MAKER[15:8];
      15'h2c: return pos[7:0];
      15'h2d: return pos[15:8];
      15'h2e: return pos[23:16];
      default: return mdl[a[5:0]];
    endcase
  endfunction

  // one command-port cycle; read data is taken in the cycle after the strobe
  task automatic cmd(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    ev <= 1'($random(seed));
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  // one serial frame through the host, waiting on its sticky done flag
  task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n;
    cmd(`SCR_H_STATUS, 8'h02, 1'b1);
    cmd(`SCR_H_TADDR_LO, a[7:0], 1'b1);
    cmd(`SCR_H_TADDR_HI, {1'b0, a[14:8]}, 1'b1);
    cmd(`SCR_H_WDATA, d, 1'b1);
    cmd(`SCR_H_CTRL, w ? 8'h01 : 8'h02, 1'b1);
    for (n = 0; n < 300 && q[1] !== 1'b1; n++) cmd(`SCR_H_STATUS, 8'h00, 1'b0);
    if (q[1] !== 1'b1) num_errors++;
    if (w) mwrite(a, d);
    else cmd(`SCR_H_RDATA, 8'h00, 1'b0);
  endtask

  task automatic rd_chk(input logic [14:0] a);
    xfer(1'b0, a, 8'h00);
    chk_byte("register read", mread(a), q);
    chk_outs("device outputs", {mdl[2][1:0] == 2'h3, mdl[41][6:0]},
             {pd, proc, recv, fine, sel});
  endtask

  task automatic ev_chk();
    @(posedge clk_sys);
    ev <= 1'b1;
    @(posedge clk_sys);
    ev <= 1'b0;
    #1 chk_outs("event taken", {7'h00, mdl[41][6] & mdl[41][5]}, {7'h00, taken});
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // main sequence: reset values, every mode code, sysref fields, chip reset
  initial begin
    mreset();
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    pos <= 24'($random(seed));
    foreach (regs[j]) rd_chk(15'(regs[j]));
    for (i = 0; i < 4; i++) begin
      xfer(1'b1, 15'h2, 8'hfc | 8'(i));
      rd_chk(15'h2);
    end
    xfer(1'b1, 15'hc, 8'hff);
    rd_chk(15'hc);
    for (i = 0; i < 6; i++) begin
      xfer(1'b1, 15'h29, 8'($random(seed)));
      rd_chk(15'h29);
      ev_chk();
    end
    xfer(1'b1, 15'h0, 8'h0f);
    rd_chk(15'h0);
    xfer(1'b1, 15'h10, 8'h01);
    rd_chk(15'h10);
    // software policy: fine scale on several windows, delay taken from the status
    xfer(1'b1, 15'h29, {3'b111, 1'($countones(pos) > 1), pos[3:0]});
    rd_chk(15'h29);
    xfer(1'b1, 15'h0, 8'h80);
    chk_outs("chip reset cycles", 8'(`SCR_RST_CYCLES), 8'(rst_cyc));
    foreach (regs[j]) rd_chk(15'(regs[j]));
    test_done();
  end
endmodule

`default_nettype wire
